// file: core/sdx_pkg.sv
// Purpose: shared constants for the card data-transfer block
// Assumes: byte addressing, 512-byte sectors
// Notes: status and config bit positions used by top and checks
package sdx_pkg;
  localparam logic [9:0]  SECTOR_LEN = 10'h200;
  localparam logic [8:0]  LAST_IX    = 9'h1ff;
  localparam logic [12:0] CRC_UNITS  = 13'h010;
  localparam logic [15:0] CRC_POLY   = 16'h1021;
  localparam int          ECC_W      = 13;
  localparam int          FILL_W     = 21;
  localparam logic [4:0]  TOKEN_OK   = 5'h05;
  localparam logic [4:0]  TOKEN_BAD  = 5'h0b;
  localparam logic [2:0]  TOKEN_END  = 3'h5;
  // config low bytes: copy, permanent and temporary protect
  localparam int          CFG_COPY   = 14;
  localparam int          CFG_PERM   = 13;
  localparam int          CFG_TMP    = 12;
  localparam logic [15:0] CFG_STICKY = 16'h6000;
  localparam logic [15:0] CFG_RESET  = 16'h0001;
  // card status bits
  localparam int          ST_ADDR    = 30;
  localparam int          ST_LEN     = 29;
  localparam int          ST_WP      = 26;
  localparam int          ST_CRC     = 23;
  localparam int          ST_ECC     = 19;
  // short status view
  localparam int          SPI_LEN    = 14;
  localparam int          SPI_ADDR   = 13;
  localparam int          SPI_CRC    = 11;
  localparam int          SPI_WP     = 5;
  localparam int          SPI_ECC    = 4;
  localparam logic [31:0] OCR_RANGE  = 32'h00ff8000;
  typedef enum logic [1:0] {KIND_READ, KIND_WRITE, KIND_STOP, KIND_PROG} kind_type;
endpackage

// file: core/byte_stream_if.sv
// Purpose: valid/ready word stream between buffer and card logic
// Assumes: both ends on the same clock
// Notes: data only moves when valid and ready are both high
`timescale 1ns/1ps
`default_nettype none
interface byte_stream_if #(parameter int W = 8);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport source (output valid, output data, input ready);
  modport sink   (input valid, input data, output ready);
endinterface
`default_nettype wire

// file: core/pair_buffer.sv
// Purpose: two-entry skid buffer on the memory fill path
// Assumes: synchronous flush, reset already synchronised
// Notes: in_ready is registered, so a full pair never overruns
`timescale 1ns/1ps
`default_nettype none
module pair_buffer #(parameter int W = 8) (
  input  wire logic       clock,
  input  wire logic       rst_n,
  input  wire logic       flush,
  input  wire logic       in_valid,
  input  wire logic [W-1:0] in_data,
  output var  logic       in_ready,
  byte_stream_if.source   out
);
  typedef struct packed {
    logic [1:0][W-1:0] ent;
    logic [1:0]        cnt;
    logic              rdy;
  } buf_type;
  buf_type r;
  buf_type n;
  logic    take;
  logic    give;
  logic [1:0] c;

  always_comb begin
    n = r;
    take = in_valid & r.rdy;
    give = out.valid & out.ready;
    c = r.cnt - {1'b0, give};
    if (give) begin
      n.ent[0] = r.ent[1];
    end
    if (take) begin
      n.ent[c[0]] = in_data;
    end
    n.cnt = c + {1'b0, take};
    if (flush) begin
      n.cnt = 2'h0;
    end
    n.rdy = n.cnt != 2'h2;
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign out.valid = r.cnt != 2'h0;
  assign out.data  = r.ent[0];
  assign in_ready  = r.rdy;

  full_stall_a: assert property (@(posedge clock) disable iff (!rst_n)
    r.cnt == 2'h2 |-> !in_ready) else $error("buffer full but ready");
  hold_word_a: assert property (@(posedge clock) disable iff (!rst_n)
    out.valid && !out.ready && !flush |=> out.valid && $stable(out.data))
    else $error("stalled word changed");
endmodule // pair_buffer
`default_nettype wire

// file: core/sd_card_block_transfer.sv
// Purpose: card-side block transfer, data crc, sector ecc, protection
// Assumes: link clock and data pins sampled by the 100 MHz clock
// Notes: command framing lives outside; commands arrive as pulses
`timescale 1ns/1ps
`default_nettype none
module sd_card_block_transfer (
  input  wire logic        clock,
  input  wire logic        resetn,
  input  wire logic        link_clk,
  input  wire logic [3:0]  dat_in,
  output logic      [3:0]  dat_out,
  output logic      [3:0]  dat_oe_n,
  input  wire logic        spi_mode,
  input  wire logic        cmd_valid,
  input  wire sdx_pkg::kind_type cmd_kind,
  input  wire logic [31:0] cmd_addr,
  input  wire logic [9:0]  cmd_len,
  input  wire logic        cmd_multi,
  input  wire logic        cmd_wide,
  input  wire logic [15:0] cmd_cfg,
  input  wire logic        status_clear,
  output logic             mem_req,
  output logic      [31:0] mem_addr,
  input  wire logic        mem_in_valid,
  input  wire logic [7:0]  mem_in_data,
  input  wire logic [12:0] mem_in_ecc,
  output logic             mem_in_ready,
  output logic             mem_out_valid,
  output logic      [7:0]  mem_out_data,
  output logic      [12:0] mem_out_ecc,
  input  wire logic        mem_out_ready,
  output logic      [15:0] cfg_low,
  output logic      [31:0] status,
  output logic      [15:0] spi_status,
  output logic      [31:0] ocr,
  output logic             busy
);
  typedef enum logic [2:0] {IDLE, FILL, SEND, RECV_WAIT, RECV, TOKEN, DRAIN} phase_type;
  typedef struct packed {
    phase_type        state;
    logic [4:0]       s1;
    logic [4:0]       s2;
    logic [4:0]       s3;
    logic [4:0]       level;
    logic [511:0][7:0] sector;
    logic [31:0]      addr;
    logic [9:0]       len;
    logic             multi;
    logic             wide;
    logic [12:0]      unit;
    logic [8:0]       byte_ix;
    logic [7:0]       shreg;
    logic [3:0][15:0] crc;
    logic [12:0]      ecc;
    logic             fix_en;
    logic [11:0]      fix_pos;
    logic             ok;
    logic [15:0]      cfg;
    logic [31:0]      status;
    logic [15:0]      spi_status;
    logic [31:0]      ocr;
    logic [3:0]       dat_out;
    logic [3:0]       dat_oe_n;
    logic             mem_req;
    logic [31:0]      mem_addr;
    logic             mem_out_valid;
    logic [7:0]       mem_out_data;
    logic [12:0]      mem_out_ecc;
    logic             busy;
  } card_type;

  card_type    r;
  card_type    n;
  logic [1:0]  rsync;
  logic        rst_n;
  logic [4:0]  filt;
  logic        cs_off;
  logic        rise;
  logic        fall;
  logic        stop;
  logic [3:0]  din;
  logic [3:0]  mask;
  logic [3:0]  lanes;
  logic [12:0] dn;
  logic [12:0] u;
  logic [12:0] e;
  logic [8:0]  b;
  logic [7:0]  bv;
  logic [7:0]  nb;
  logic [4:0]  tok;
  logic [31:0] ev;

  byte_stream_if #(.W(sdx_pkg::FILL_W)) fill_bus ();

  function automatic logic [15:0] crc16_step(input logic [15:0] c, input logic d);
    crc16_step = {c[14:0], 1'b0} ^ ((c[15] ^ d) ? sdx_pkg::CRC_POLY : 16'h0000);
  endfunction

  // position code: parity plus xor of set-bit positions fixes one flip
  function automatic logic [12:0] ecc_byte(input logic [8:0] bi, input logic [7:0] d);
    logic [2:0] p;
    p = 3'h0;
    for (int j = 0; j < 8; j++) begin
      if (d[j]) begin
        p = p ^ 3'(j);
      end
    end
    ecc_byte = {^d, (^d) ? bi : 9'h000, p};
  endfunction

  function automatic logic [12:0] data_units(input logic [9:0] l, input logic w);
    data_units = w ? {2'h0, l, 1'b0} : {l, 3'h0};
  endfunction

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rsync <= 2'h0;
    end else begin
      rsync <= {rsync[0], 1'b1};
    end
  end
  assign rst_n = rsync[1];

  pair_buffer #(.W(sdx_pkg::FILL_W)) fill_buf (
    .clock    (clock),
    .rst_n    (rst_n),
    .flush    (stop),
    .in_valid (mem_in_valid),
    .in_data  ({mem_in_ecc, mem_in_data}),
    .in_ready (mem_in_ready),
    .out      (fill_bus)
  );
  assign fill_bus.ready = r.state == FILL;
  assign stop = cmd_valid && cmd_kind == sdx_pkg::KIND_STOP;

  always_comb begin
    n = r;
    ev = 32'h0;
    b = 9'h000;
    bv = 8'h00;
    nb = 8'h00;
    e = 13'h0000;
    lanes = 4'h0;
    tok = r.ok ? sdx_pkg::TOKEN_OK : sdx_pkg::TOKEN_BAD;
    // three-stage sampler; a link edge needs 4 system clocks, so 50 Mb/s needs a faster clock
    n.s1 = {dat_in, link_clk};
    n.s2 = r.s1;
    n.s3 = r.s2;
    for (int i = 0; i < 5; i++) begin
      filt[i] = (r.s2[i] == r.s3[i]) ? r.s3[i] : r.level[i];
    end
    n.level = filt;
    cs_off = spi_mode & filt[4];
    rise = filt[0] & ~r.level[0] & ~cs_off;
    fall = ~filt[0] & r.level[0] & ~cs_off;
    din = filt[4:1];
    mask = r.wide ? 4'hf : 4'h1;
    dn = data_units(r.len, r.wide);
    u = r.unit - 13'h0001;
    case (r.state)
      IDLE: begin
        if (cmd_valid) begin
          n.wide = cmd_wide & ~spi_mode;
          n.addr = cmd_addr;
          n.len = cmd_len;
          n.multi = cmd_multi;
          n.unit = 13'h0000;
          n.byte_ix = 9'h000;
          n.ecc = 13'h0000;
          case (cmd_kind)
            sdx_pkg::KIND_READ: begin
              if (cmd_len == 10'h000 || cmd_len > sdx_pkg::SECTOR_LEN) begin
                ev[sdx_pkg::ST_LEN] = 1'b1;
              end else if ({2'h0, cmd_addr[8:0]} + {1'b0, cmd_len} >
                           {1'b0, sdx_pkg::SECTOR_LEN}) begin
                ev[sdx_pkg::ST_ADDR] = 1'b1;
              end else begin
                n.state = FILL;
                n.mem_req = 1'b1;
                n.mem_addr = {cmd_addr[31:9], 9'h000};
              end
            end
            sdx_pkg::KIND_WRITE: begin
              if (cmd_len != sdx_pkg::SECTOR_LEN) begin
                ev[sdx_pkg::ST_LEN] = 1'b1;
              end else if (cmd_addr[8:0] != 9'h000) begin
                ev[sdx_pkg::ST_ADDR] = 1'b1;
              end else if (r.cfg[sdx_pkg::CFG_PERM] | r.cfg[sdx_pkg::CFG_TMP]) begin
                ev[sdx_pkg::ST_WP] = 1'b1;
              end else begin
                n.state = RECV_WAIT;
              end
            end
            sdx_pkg::KIND_PROG: begin
              // upper bytes are factory data outside this block
              n.cfg = cmd_cfg | (r.cfg & sdx_pkg::CFG_STICKY);
            end
            default: begin
            end
          endcase
        end
      end
      FILL: begin
        if (fill_bus.valid) begin
          n.sector[r.byte_ix] = fill_bus.data[7:0];
          e = r.ecc ^ ecc_byte(r.byte_ix, fill_bus.data[7:0]);
          n.ecc = e;
          n.byte_ix = r.byte_ix + 9'h001;
          if (r.byte_ix == sdx_pkg::LAST_IX) begin
            e = e ^ fill_bus.data[20:8];
            n.fix_en = e[12];
            n.fix_pos = e[11:0];
            if (!e[12] && e[11:0] != 12'h000) begin
              ev[sdx_pkg::ST_ECC] = 1'b1;
            end
            n.mem_req = 1'b0;
            n.state = SEND;
            n.unit = 13'h0000;
          end
        end
      end
      SEND: begin
        if (fall) begin
          n.unit = r.unit + 13'h0001;
          if (r.unit == 13'h0000) begin
            n.dat_out = 4'h0;
            n.dat_oe_n = ~mask;
            n.crc = '0;
          end else if (r.unit <= dn) begin
            b = r.addr[8:0] + (r.wide ? u[9:1] : u[11:3]);
            bv = r.sector[b] ^ ((r.fix_en && r.fix_pos[11:3] == b) ?
                 (8'h01 << r.fix_pos[2:0]) : 8'h00);
            lanes = r.wide ? (u[0] ? bv[3:0] : bv[7:4]) : {3'h0, bv[3'h7 - u[2:0]]};
            n.dat_out = lanes;
            for (int i = 0; i < 4; i++) begin
              n.crc[i] = crc16_step(r.crc[i], lanes[i]);
            end
          end else if (r.unit <= dn + sdx_pkg::CRC_UNITS) begin
            for (int i = 0; i < 4; i++) begin
              n.dat_out[i] = r.crc[i][15];
              n.crc[i] = {r.crc[i][14:0], 1'b0};
            end
          end else if (r.unit == dn + sdx_pkg::CRC_UNITS + 13'h0001) begin
            n.dat_out = 4'hf;
          end else begin
            n.dat_oe_n = 4'hf;
            n.unit = 13'h0000;
            if (r.multi) begin
              // host keeps each next block inside one sector
              n.addr = r.addr + {22'h0, r.len};
              n.state = FILL;
              n.mem_req = 1'b1;
              n.mem_addr = {n.addr[31:9], 9'h000};
              n.byte_ix = 9'h000;
              n.ecc = 13'h0000;
            end else begin
              n.state = IDLE;
            end
          end
        end
      end
      RECV_WAIT: begin
        if (rise && !din[0]) begin
          n.state = RECV;
          n.unit = 13'h0000;
          n.crc = '0;
          n.ecc = 13'h0000;
        end
      end
      RECV: begin
        if (rise) begin
          n.unit = r.unit + 13'h0001;
          if (r.unit < dn + sdx_pkg::CRC_UNITS) begin
            // crc over data and its own check word leaves zero
            for (int i = 0; i < 4; i++) begin
              n.crc[i] = crc16_step(r.crc[i], din[i]);
            end
          end
          if (r.unit < dn) begin
            nb = r.wide ? {r.shreg[3:0], din} : {r.shreg[6:0], din[0]};
            n.shreg = nb;
            if (r.wide ? r.unit[0] : (r.unit[2:0] == 3'h7)) begin
              b = r.wide ? r.unit[9:1] : r.unit[11:3];
              n.sector[b] = nb;
              n.ecc = r.ecc ^ ecc_byte(b, nb);
            end
          end else if (r.unit == dn + sdx_pkg::CRC_UNITS) begin
            n.ok = r.crc[0] == 16'h0000 &&
                   (!r.wide || (r.crc[1] | r.crc[2] | r.crc[3]) == 16'h0000);
            n.state = TOKEN;
            n.unit = 13'h0000;
          end
        end
      end
      TOKEN: begin
        if (fall) begin
          if (r.unit[2:0] < sdx_pkg::TOKEN_END) begin
            n.dat_oe_n[0] = 1'b0;
            n.dat_out[0] = tok[3'h4 - r.unit[2:0]];
            n.unit = r.unit + 13'h0001;
          end else if (r.ok) begin
            n.dat_out[0] = 1'b0;
            n.state = DRAIN;
            n.byte_ix = 9'h000;
            n.mem_addr = {r.addr[31:9], 9'h000};
          end else begin
            ev[sdx_pkg::ST_CRC] = 1'b1;
            n.dat_oe_n = 4'hf;
            n.state = IDLE;
          end
        end
      end
      DRAIN: begin
        // lane 0 held low as busy until the sector is handed over
        if (!r.mem_out_valid) begin
          n.mem_out_valid = 1'b1;
          n.mem_out_data = r.sector[r.byte_ix];
          n.mem_out_ecc = r.ecc;
        end else if (mem_out_ready) begin
          if (r.byte_ix == sdx_pkg::LAST_IX) begin
            n.mem_out_valid = 1'b0;
            n.dat_oe_n = 4'hf;
            n.dat_out = 4'hf;
            if (r.multi) begin
              n.addr = r.addr + {22'h0, sdx_pkg::SECTOR_LEN};
              n.state = RECV_WAIT;
            end else begin
              n.state = IDLE;
            end
          end else begin
            n.byte_ix = r.byte_ix + 9'h001;
            n.mem_out_data = r.sector[r.byte_ix + 9'h001];
          end
        end
      end
      default: begin
        n.state = IDLE;
      end
    endcase
    // a sector already accepted is still programmed after a stop
    if (stop) begin
      n.multi = 1'b0;
      if (r.state != DRAIN && r.state != TOKEN) begin
        n.state = IDLE;
        n.dat_oe_n = 4'hf;
        n.mem_req = 1'b0;
      end
    end
    n.status = status_clear ? ev : (r.status | ev);
    n.spi_status = 16'h0000;
    n.spi_status[sdx_pkg::SPI_LEN] = n.status[sdx_pkg::ST_LEN];
    n.spi_status[sdx_pkg::SPI_ADDR] = n.status[sdx_pkg::ST_ADDR];
    n.spi_status[sdx_pkg::SPI_CRC] = n.status[sdx_pkg::ST_CRC];
    n.spi_status[sdx_pkg::SPI_WP] = n.status[sdx_pkg::ST_WP];
    n.spi_status[sdx_pkg::SPI_ECC] = n.status[sdx_pkg::ST_ECC];
    n.busy = n.state != IDLE;
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      r <= '0;
      r.cfg <= sdx_pkg::CFG_RESET;
      r.ocr <= sdx_pkg::OCR_RANGE;
      r.dat_out <= 4'hf;
      r.dat_oe_n <= 4'hf;
    end else begin
      r <= n;
    end
  end

  assign dat_out       = r.dat_out;
  assign dat_oe_n      = r.dat_oe_n;
  assign mem_req       = r.mem_req;
  assign mem_addr      = r.mem_addr;
  assign mem_out_valid = r.mem_out_valid;
  assign mem_out_data  = r.mem_out_data;
  assign mem_out_ecc   = r.mem_out_ecc;
  assign cfg_low       = r.cfg;
  assign status        = r.status;
  assign spi_status    = r.spi_status;
  assign ocr           = r.ocr;
  assign busy          = r.busy;

  default clocking dc @(posedge clock); endclocking
  default disable iff (!rst_n);

  perm_wp_hold_a: assert property ($past(r.cfg[sdx_pkg::CFG_PERM]) |-> r.cfg[sdx_pkg::CFG_PERM])
    else $error("permanent protect cleared");
  copy_flag_hold_a: assert property ($past(r.cfg[sdx_pkg::CFG_COPY]) |-> r.cfg[sdx_pkg::CFG_COPY])
    else $error("copy flag cleared");
  cfg_program_a: assert property (cmd_valid && cmd_kind == sdx_pkg::KIND_PROG && r.state == IDLE
    |=> r.cfg[11:0] == $past(cmd_cfg[11:0])) else $error("config low bytes not written");
  write_refuse_a: assert property (cmd_valid && cmd_kind == sdx_pkg::KIND_WRITE && r.state == IDLE
    && cmd_len == sdx_pkg::SECTOR_LEN && cmd_addr[8:0] == 9'h000
    && (r.cfg[sdx_pkg::CFG_PERM] || r.cfg[sdx_pkg::CFG_TMP])
    |=> r.state == IDLE && r.status[sdx_pkg::ST_WP]) else $error("protected write taken");
  stop_ends_a: assert property (stop && r.state inside {FILL, SEND, RECV_WAIT, RECV}
    |=> r.state == IDLE && r.dat_oe_n == 4'hf ##1 !busy) else $error("stop ignored");
  narrow_lane_a: assert property (!r.wide |-> r.dat_oe_n[3:1] == 3'h7)
    else $error("unused lane driven");
  next_block_a: assert property (r.state == SEND && n.state == FILL
    |=> r.addr == $past(r.addr) + {22'h0, r.len} && r.mem_req) else $error("bad next address");
  read_len_a: assert property (cmd_valid && cmd_kind == sdx_pkg::KIND_READ && r.state == IDLE
    && cmd_len == 10'h000 |=> r.state == IDLE && r.status[sdx_pkg::ST_LEN])
    else $error("zero length read taken");
  crc_flag_a: assert property ($rose(r.status[sdx_pkg::ST_CRC]) |-> $past(r.state) == TOKEN)
    else $error("crc error outside token");
  spi_view_a: assert property (r.spi_status[sdx_pkg::SPI_WP] == r.status[sdx_pkg::ST_WP])
    else $error("short status mismatch");
endmodule // sd_card_block_transfer
`default_nettype wire

// file: tb/link_host.sv
// Purpose: host side of the card link, clock and data lanes
// Assumes: lanes carry pull-ups, link clock idles low outside frames
// Notes: card drive wins over host drive on any lane
`timescale 1ns/1ps
`default_nettype none
module link_host (
  input  wire logic       run,
  input  wire logic       host_oe,
  input  wire logic [3:0] host_dat,
  input  wire logic [3:0] dat_out,
  input  wire logic [3:0] dat_oe_n,
  output var  logic       link_clk,
  output var  logic [3:0] dat_in
);
  // odd offset keeps the link unrelated in phase to the system clock
  initial begin
    link_clk = 1'b0;
    #3.3;
    forever #62.5 link_clk = run ? ~link_clk : 1'b0;
  end
  // released lanes go to the pull-up; lane3 high keeps an spi card deselected
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      dat_in[i] = !dat_oe_n[i] ? dat_out[i] : (host_oe ? host_dat[i] : 1'b1);
    end
  end
endmodule // link_host
`default_nettype wire

// file: tb/sd_card_block_transfer_tb.sv
// Purpose: self-checking bench for the card block transfer
// Assumes: memory side played here, link host in link_host
// Notes: single lane read, four lane write, stop and protection
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, x) begin cmp_count++; if ((g) !== (x)) begin bad_count++; $display("[ERR] %0t got %h exp %h", $time, g, x); end end
module sd_card_block_transfer_tb;
  typedef struct packed {logic [1:0] k; logic [31:0] a; logic [9:0] l; logic [31:0] st; logic [15:0] sp;} row_type;
  logic clock, resetn, spi_mode, cmd_valid, cmd_multi, cmd_wide, status_clear, run, host_oe;
  logic mem_in_valid, mem_out_ready, mem_req, mem_in_ready, mem_out_valid, busy, link_clk;
  logic [3:0] dat_in, dat_out, dat_oe_n, host_dat;
  sdx_pkg::kind_type cmd_kind;
  logic [31:0] cmd_addr, mem_addr, status, ocr;
  logic [9:0] cmd_len;
  logic [15:0] cmd_cfg, cfg_low, spi_status, c [4];
  logic [7:0] mem_in_data, mem_out_data, d [512];
  logic [12:0] mem_in_ecc, mem_out_ecc, e;
  logic [4:0] tok;
  int bad_count, cmp_count, cyc, n;
  row_type rows [5] = '{'{2'h0, 32'h0, 10'h0, 32'h20000000, 16'h4000},
    '{2'h0, 32'h0, 10'h201, 32'h20000000, 16'h4000}, '{2'h0, 32'h1f0, 10'h20, 32'h40000000, 16'h2000},
    '{2'h1, 32'h0, 10'h100, 32'h20000000, 16'h4000}, '{2'h1, 32'h10, 10'h200, 32'h40000000, 16'h2000}};

  sd_card_block_transfer u_dut (.clock(clock), .resetn(resetn), .link_clk(link_clk),
    .dat_in(dat_in), .dat_out(dat_out), .dat_oe_n(dat_oe_n), .spi_mode(spi_mode),
    .cmd_valid(cmd_valid), .cmd_kind(cmd_kind), .cmd_addr(cmd_addr), .cmd_len(cmd_len),
    .cmd_multi(cmd_multi), .cmd_wide(cmd_wide), .cmd_cfg(cmd_cfg), .status_clear(status_clear),
    .mem_req(mem_req), .mem_addr(mem_addr), .mem_in_valid(mem_in_valid), .mem_in_data(mem_in_data),
    .mem_in_ecc(mem_in_ecc), .mem_in_ready(mem_in_ready), .mem_out_valid(mem_out_valid),
    .mem_out_data(mem_out_data), .mem_out_ecc(mem_out_ecc), .mem_out_ready(mem_out_ready),
    .cfg_low(cfg_low), .status(status), .spi_status(spi_status), .ocr(ocr), .busy(busy));
  link_host u_host (.run(run), .host_oe(host_oe), .host_dat(host_dat), .dat_out(dat_out),
    .dat_oe_n(dat_oe_n), .link_clk(link_clk), .dat_in(dat_in));

  // per-lane crc over a byte run; wide splits each byte over four lanes
  function automatic logic [15:0] crc(input int ln, input int off, input int cnt, input bit w);
    logic [15:0] r;
    int k;
    r = 16'h0000;
    for (int i = 0; i < cnt * 8; i++) begin
      k = 7 - i % 8;
      if (w ? (k % 4 == ln) : (ln == 0))
        r = {r[14:0], 1'b0} ^ ((d[off + i / 8][k] ^ r[15]) ? sdx_pkg::CRC_POLY : 16'h0000);
    end
    return r;
  endfunction

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic cmd(input logic [1:0] k, input logic [31:0] a, input logic [9:0] l,
                     input logic m, input logic w, input logic [15:0] g);
    @(negedge clock);
    cmd_kind = sdx_pkg::kind_type'(k);
    {cmd_addr, cmd_len, cmd_multi, cmd_wide, cmd_cfg, cmd_valid} = {a, l, m, w, g, 1'b1};
    @(negedge clock);
    cmd_valid = 1'b0;
    @(negedge clock);
  endtask

  // ready is registered, so its value at the falling edge is what the next rise sees
  task automatic fill(input logic [7:0] fl);
    @(negedge clock);
    for (int i = 0; i < 512; i++) begin
      {mem_in_valid, mem_in_data} = {1'b1, d[i] ^ (i == 510 ? fl : 8'h00)};
      while (mem_in_ready !== 1'b1) @(negedge clock);
      @(negedge clock);
    end
    mem_in_valid = 1'b0;
  endtask

  task automatic hbit(input logic [3:0] v);
    @(negedge link_clk);
    {host_oe, host_dat} = {1'b1, v};
  endtask

  task automatic wstart();
    n = 0;
    do @(posedge link_clk); while (dat_oe_n[0] !== 1'b0 && ++n < 40);
  endtask

  task automatic idle();
    n = 0;
    while (busy !== 1'b0 && n++ < 3000) @(negedge clock);
  endtask

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  always @(posedge clock) begin
    cyc++;
    if (cyc == 60000) begin
      bad_count++;
      close_out();
    end
  end

  initial begin
    {resetn, spi_mode, cmd_valid, cmd_multi, cmd_wide, status_clear, run, host_oe} = 8'h00;
    {mem_in_valid, mem_out_ready, host_dat, cmd_addr, cmd_len, cmd_cfg} = '0;
    {mem_in_data, mem_in_ecc} = '0;
    cmd_kind = sdx_pkg::KIND_READ;
    e = 13'h0000;
    for (int i = 0; i < 512; i++) begin
      d[i] = 8'(i * 7 + 3);
      for (int k = 0; k < 8; k++)
        if (d[i][k]) e = e ^ {1'b1, 9'(i), 3'(k)};
    end
    mem_in_ecc = e;
    repeat (12) @(negedge clock);
    resetn = 1'b1;
    repeat (3) @(negedge clock);
    `CHK({dat_oe_n, cfg_low, status, busy}, {4'hf, 16'h0001, 32'h0, 1'b0})
    `CHK(ocr, sdx_pkg::OCR_RANGE)
    foreach (rows[i]) begin
      spi_mode = i[0];
      cmd(rows[i].k, rows[i].a, rows[i].l, 1'b0, 1'b0, 16'h0);
      `CHK(status, rows[i].st)
      `CHK(spi_status, rows[i].sp)
      status_clear = 1'b1;
      @(negedge clock);
      status_clear = 1'b0;
    end
    // spi read: host holds the select lane low so link edges count
    {spi_mode, host_oe, host_dat} = {1'b1, 1'b1, 4'h0};
    // last two bytes of a sector, one flipped bit handed over for correction
    cmd(sdx_pkg::KIND_READ, 32'h1fe, 10'h2, 1'b0, 1'b0, 16'h0);
    `CHK({mem_req, mem_addr}, {1'b1, 32'h0})
    fill(8'h10);
    run = 1'b1;
    c[0] = crc(0, 510, 2, 1'b0);
    wstart();
    `CHK(dat_out[0], 1'b0)
    for (int i = 0; i < 33; i++) begin
      @(posedge link_clk);
      `CHK(dat_out[0], i < 16 ? d[510 + i / 8][7 - i % 8] : (i < 32 ? c[0][31 - i] : 1'b1))
    end
    repeat (3) @(posedge link_clk);
    run = 1'b0;
    `CHK({dat_oe_n, busy}, {4'hf, 1'b0})
    {spi_mode, host_oe} = 2'b00;
    // second pass spoils one crc bit on every lane; the card must refuse it
    for (int p = 0; p < 2; p++) begin
      cmd(sdx_pkg::KIND_WRITE, 32'h200, 10'h200, 1'b0, 1'b1, 16'h0);
      run = 1'b1;
      hbit(4'h0);
      for (int i = 0; i < 512; i++) begin
        hbit(d[i][7:4]);
        hbit(d[i][3:0]);
      end
      for (int j = 0; j < 4; j++) c[j] = crc(j, 0, 512, 1'b1) ^ 16'(p);
      for (int b = 15; b >= 0; b--) hbit({c[3][b], c[2][b], c[1][b], c[0][b]});
      hbit(4'hf);
      @(negedge link_clk);
      host_oe = 1'b0;
      wstart();
      tok[4] = dat_out[0];
      for (int i = 3; i >= 0; i--) begin
        @(posedge link_clk);
        tok[i] = dat_out[0];
      end
      `CHK(tok, p ? sdx_pkg::TOKEN_BAD : sdx_pkg::TOKEN_OK)
      n = 0;
      // the memory drops ready one cycle in three while the sector drains
      for (int j = 0; j < 20000 && n < 512 && p == 0; j++) begin
        @(negedge clock);
        mem_out_ready = (j % 3 != 0);
        if (mem_out_valid === 1'b1 && mem_out_ready) begin
          `CHK({mem_out_data, mem_out_ecc}, {d[n], e})
          n++;
        end
      end
      idle();
      run = 1'b0;
      `CHK({busy, mem_out_valid, status[23]}, {2'b00, p[0]})
      `CHK(spi_status[11], p[0])
    end
    // two-byte blocks, so the second block needs its own refill
    cmd(sdx_pkg::KIND_READ, 32'h0, 10'h2, 1'b1, 1'b0, 16'h0);
    fill(8'h00);
    run = 1'b1;
    wstart();
    repeat (36) @(posedge link_clk);
    `CHK({mem_req, mem_addr, busy}, {1'b1, 32'h0, 1'b1})
    fill(8'h00);
    wstart();
    @(posedge link_clk);
    `CHK(dat_out[0], d[2][7])
    cmd(sdx_pkg::KIND_STOP, 32'h0, 10'h0, 1'b0, 1'b0, 16'h0);
    idle();
    run = 1'b0;
    `CHK(busy, 1'b0)
    cmd(sdx_pkg::KIND_PROG, 32'h0, 10'h0, 1'b0, 1'b0, 16'h7000);
    `CHK(cfg_low, 16'h7000)
    cmd(sdx_pkg::KIND_PROG, 32'h0, 10'h0, 1'b0, 1'b0, 16'h0000);
    `CHK(cfg_low, 16'h6000)
    cmd(sdx_pkg::KIND_WRITE, 32'h0, 10'h200, 1'b0, 1'b0, 16'h0);
    `CHK({status[26], spi_status[5], busy}, 3'b110)
    // mid-run reset, then the first command after release must be seen: a zero-length read refused with the length flag
    resetn = 1'b0;
    @(negedge clock);
    `CHK({dat_oe_n, status, busy, ocr}, {4'hf, 32'h0, 1'b0, sdx_pkg::OCR_RANGE})
    resetn = 1'b1;
    repeat (3) @(negedge clock);
    cmd(sdx_pkg::KIND_READ, 32'h0, 10'h0, 1'b0, 1'b0, 16'h0);
    `CHK({status[29], busy}, 2'b10)
    close_out();
  end
endmodule // sd_card_block_transfer_tb
`default_nettype wire
